//--- src/spc_pkg.sv
package spc_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_PROFILE   = 32'hf1000550;
  localparam logic [31:0] ADDR_FRM_CTRL  = 32'hf1000610;
  localparam logic [31:0] ADDR_FRM_VALUE = 32'hf1000614;
  localparam logic [31:0] ADDR_TRG_CTRL  = 32'hf1000620;
  localparam logic [31:0] ADDR_TRG_VALUE = 32'hf1000624;

  // ----------------------------------------------------------------
  // field positions (bit 0 of the bus word is the msb, bit 31 here)
  // ----------------------------------------------------------------
  localparam int BIT_PRESENT = 31;
  localparam int BIT_CLEAR   = 30;
  localparam int BIT_STAMP   = 25;
  localparam int BIT_STORE   = 23;
  localparam int BIT_LOAD    = 22;
  localparam int BIT_BOOT    = 21;
  localparam int FAULT_LSB   = 8;
  localparam int ROW_LSB     = 0;

  // ----------------------------------------------------------------
  // fault results
  // ----------------------------------------------------------------
  localparam logic [3:0] FAULT_NONE      = 4'h0;
  localparam logic [3:0] FAULT_CORRUPT   = 4'h1;
  localparam logic [3:0] FAULT_NOT_IDLE  = 4'h2;
  localparam logic [3:0] FAULT_ABSENT    = 4'h3;
  localparam logic [3:0] FAULT_NO_SLOT   = 4'h4;
  localparam logic [3:0] FAULT_RANGE     = 4'h5;
  localparam logic [3:0] FAULT_DEFAULT   = 4'h6;
  localparam logic [3:0] FAULT_LUT_LOAD  = 4'h7;
  localparam logic [3:0] FAULT_LUT_STORE = 4'h8;

  // ----------------------------------------------------------------
  // profile slots and stamp byte window
  // ----------------------------------------------------------------
  localparam logic [3:0]  LAST_SLOT      = 4'h3;
  localparam logic [15:0] FRM_BYTE_FIRST = 16'h0004;
  localparam logic [15:0] TRG_BYTE_FIRST = 16'h0008;
  localparam logic [15:0] TRG_BYTE_LAST  = 16'h000b;
  localparam logic [3:0]  RST_SLOT       = 4'h0;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
  } spc_req_t;

  // what one profile holds; the table enable bit is deliberately absent
  typedef struct packed {
    logic [31:0] settings;
    logic [3:0]  table_select;
    logic        stamp_on;
    logic [15:0] stamp_row;
  } spc_prof_t;

  localparam spc_prof_t FACTORY_PROFILE = '{
    settings:     32'h0000_0000,
    table_select: 4'h0,
    stamp_on:     1'b0,
    stamp_row:    16'h0000
  };

  typedef enum logic [3:0] {
    OP_STORE = 4'b0001,
    OP_LOAD  = 4'b0010,
    OP_BOOT  = 4'b0100,
    OP_START = 4'b1000
  } spc_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_APPLY = 3'b100
  } spc_state_t;

endpackage : spc_pkg

//--- src/spc_stamp_ctr.sv
`timescale 1ns/1ps
`default_nettype none

module spc_stamp_ctr (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        clr,
  input  wire logic        inc,
  output var  logic [31:0] count
);

  // an event in the clearing cycle is counted, so it is not lost
  logic [31:0] count_reg;
  logic [31:0] count_next;

  assign count_next = (clr ? 32'h0000_0000 : count_reg)
                    + {31'h0000_0000, inc};
  assign count      = count_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_reg <= 32'h0000_0000;
    else if (ce)
      count_reg <= count_next;
  end

endmodule : spc_stamp_ctr

`default_nettype wire

//--- src/spc_prof_mem.sv
`timescale 1ns/1ps
`default_nettype none

module spc_prof_mem (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              wr_en,
  input  wire logic [1:0]        wr_slot,
  input  wire spc_pkg::spc_prof_t wr_data,
  input  wire logic [1:0]        rd_slot,
  output var  spc_pkg::spc_prof_t rd_data,
  output var  logic              rd_exists
);

  // slot zero is wired to the factory profile and has no storage
  spc_pkg::spc_prof_t mem_q [1:3];
  logic [3:1]         used_reg;

  // slot zero always exists; its flag is not a flip-flop
  wire rd_used = (rd_slot == 2'h0) ? 1'b1 : used_reg[rd_slot];

  genvar g;
  generate
    for (g = 1; g <= 3; g++)
    begin : g_slot
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          used_reg[g] <= 1'b0;
        else if (ce && wr_en && wr_slot == 2'(g))
        begin
          used_reg[g] <= 1'b1;
          mem_q[g]    <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data   <= spc_pkg::FACTORY_PROFILE;
      rd_exists <= 1'b0;
    end
    else if (ce)
    begin
      rd_data   <= (rd_slot == 2'h0) ? spc_pkg::FACTORY_PROFILE
                                     : mem_q[rd_slot];
      rd_exists <= rd_used;
    end
  end

endmodule : spc_prof_mem

`default_nettype wire

//--- src/spc_top.sv
`timescale 1ns/1ps
`default_nettype none

module spc_top (
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  input  wire spc_pkg::spc_req_t BUS_REQ,
  output var  logic              RESP_VALID,
  output var  logic [31:0]       RD_DATA,
  input  wire logic              FRAME_DONE,
  input  wire logic              TRIG_SEEN,
  input  wire logic              INIT_CMD,
  input  wire logic              CAPTURE_BUSY,
  input  wire logic [31:0]       SETTINGS_IN,
  input  wire logic [3:0]        TABLE_SEL_IN,
  output var  logic              CAPTURE_STOP,
  output var  logic              SETTINGS_LOAD,
  output var  spc_pkg::spc_prof_t SETTINGS_OUT,
  input  wire logic              PIX_VALID,
  input  wire logic [15:0]       LINE_NUM,
  input  wire logic [15:0]       BYTE_IDX,
  input  wire logic [15:0]       IMG_HEIGHT,
  output var  logic              STAMP_VALID,
  output var  logic [7:0]        STAMP_DATA
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  spc_pkg::spc_state_t state_reg;
  spc_pkg::spc_op_t    op_reg;
  logic [3:0]          id_reg;
  logic [3:0]          fault_reg;
  logic [3:0]          slot_reg;
  logic [3:0]          default_reg;
  logic                stamp_on_reg;
  logic [15:0]         stamp_row_reg;
  logic [31:0]         frm_cnt;
  logic [31:0]         trg_cnt;
  spc_pkg::spc_prof_t  mem_rd;
  logic                mem_exists;

  wire idle     = (state_reg == spc_pkg::ST_IDLE);
  wire take     = BUS_REQ.valid && idle;
  wire wr       = take && BUS_REQ.write;
  wire hit_prof = (BUS_REQ.addr == spc_pkg::ADDR_PROFILE);
  wire hit_frm  = (BUS_REQ.addr == spc_pkg::ADDR_FRM_CTRL);
  wire hit_trg  = (BUS_REQ.addr == spc_pkg::ADDR_TRG_CTRL);
  wire wr_prof  = wr && hit_prof;
  wire wr_stamp = wr && (hit_frm || hit_trg);
  wire frm_clr  = wr && hit_frm && BUS_REQ.data[spc_pkg::BIT_CLEAR];
  wire trg_clr  = wr && hit_trg && BUS_REQ.data[spc_pkg::BIT_CLEAR];
  wire req_store = BUS_REQ.data[spc_pkg::BIT_STORE];
  wire req_load  = BUS_REQ.data[spc_pkg::BIT_LOAD];
  wire req_boot  = BUS_REQ.data[spc_pkg::BIT_BOOT];
  // priority store over load over boot-choice when several bits are set
  wire start_op  = wr_prof && (req_store || req_load || req_boot);
  wire boot_go   = idle && !BUS_REQ.valid && INIT_CMD;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  spc_stamp_ctr u_frm_ctr (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .clr   (frm_clr),
    .inc   (FRAME_DONE),
    .count (frm_cnt)
  );

  spc_stamp_ctr u_trg_ctr (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .clr   (trg_clr),
    .inc   (TRIG_SEEN),
    .count (trg_cnt)
  );

  // ----------------------------------------------------------------
  // profile store
  // ----------------------------------------------------------------
  wire in_apply   = (state_reg == spc_pkg::ST_APPLY);
  wire id_bad     = (id_reg > spc_pkg::LAST_SLOT);
  wire is_store   = (op_reg == spc_pkg::OP_STORE);
  wire is_load    = (op_reg == spc_pkg::OP_LOAD);
  wire is_choice  = (op_reg == spc_pkg::OP_BOOT);
  wire is_start   = (op_reg == spc_pkg::OP_START);
  // slot zero is never written
  wire mem_wr     = in_apply && is_store && !id_bad && id_reg != 4'h0;

  spc_pkg::spc_prof_t snap;
  assign snap = '{settings:     SETTINGS_IN,
                  table_select: TABLE_SEL_IN,
                  stamp_on:     stamp_on_reg,
                  stamp_row:    stamp_row_reg};

  spc_prof_mem u_mem (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .ce        (CE),
    .wr_en     (mem_wr),
    .wr_slot   (id_reg[1:0]),
    .wr_data   (snap),
    .rd_slot   (id_reg[1:0]),
    .rd_data   (mem_rd),
    .rd_exists (mem_exists)
  );

  // load outcome; any failed load falls back to factory data
  wire load_busy = is_load && CAPTURE_BUSY;
  wire load_ok   = (is_load || is_start) && !id_bad && mem_exists
                 && !load_busy;
  wire load_do   = in_apply && (is_load || is_start);
  spc_pkg::spc_prof_t load_data;
  assign load_data = load_ok ? mem_rd : spc_pkg::FACTORY_PROFILE;

  logic [3:0] fault_next;
  assign fault_next =
      (is_store && (id_bad || id_reg == 4'h0)) ? spc_pkg::FAULT_RANGE :
      load_busy                                ? spc_pkg::FAULT_NOT_IDLE :
      (!is_store && id_bad)                    ? spc_pkg::FAULT_RANGE :
      (!is_store && !mem_exists)               ? spc_pkg::FAULT_NO_SLOT :
                                                 spc_pkg::FAULT_NONE;

  // ----------------------------------------------------------------
  // sequencer: one profile operation at a time
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      state_reg <= spc_pkg::ST_READ;
      op_reg    <= spc_pkg::OP_START;
      id_reg    <= spc_pkg::RST_SLOT;
    end
    else if (CE)
    begin
      case (state_reg)
        spc_pkg::ST_IDLE:
        begin
          if (start_op)
          begin
            state_reg <= spc_pkg::ST_READ;
            id_reg    <= BUS_REQ.data[3:0];
            op_reg    <= req_store ? spc_pkg::OP_STORE :
                         req_load  ? spc_pkg::OP_LOAD  : spc_pkg::OP_BOOT;
          end
          else if (boot_go)
          begin
            state_reg <= spc_pkg::ST_READ;
            id_reg    <= default_reg;
            op_reg    <= spc_pkg::OP_START;
          end
        end
        spc_pkg::ST_READ:  state_reg <= spc_pkg::ST_APPLY;
        spc_pkg::ST_APPLY: state_reg <= spc_pkg::ST_IDLE;
        default:           state_reg <= spc_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // profile control state
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      fault_reg   <= spc_pkg::FAULT_NONE;
      slot_reg    <= spc_pkg::RST_SLOT;
      default_reg <= spc_pkg::RST_SLOT;
    end
    else if (CE)
    begin
      if (wr_prof)
        fault_reg <= spc_pkg::FAULT_NONE;
      else if (in_apply && !is_start)
        fault_reg <= fault_next;
      if (load_do)
        slot_reg <= load_ok ? id_reg : 4'h0;
      if (in_apply && is_choice && fault_next == spc_pkg::FAULT_NONE)
        default_reg <= id_reg;
    end
  end

  // ----------------------------------------------------------------
  // shared stamp settings
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      stamp_on_reg  <= spc_pkg::FACTORY_PROFILE.stamp_on;
      stamp_row_reg <= spc_pkg::FACTORY_PROFILE.stamp_row;
    end
    else if (CE)
    begin
      if (load_do)
      begin
        stamp_on_reg  <= load_data.stamp_on;
        stamp_row_reg <= load_data.stamp_row;
      end
      else if (wr_stamp)
      begin
        stamp_on_reg  <= BUS_REQ.data[spc_pkg::BIT_STAMP];
        stamp_row_reg <= BUS_REQ.data[spc_pkg::ROW_LSB +: 16];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data; reserved bits stay zero
  // ----------------------------------------------------------------
  wire [31:0] stamp_word = {1'b1, 5'h00, stamp_on_reg, 9'h000,
                            stamp_row_reg};
  wire [31:0] prof_word  = {1'b1, 19'h00000, fault_reg, 4'h0,
                            slot_reg};
  wire [31:0] rd_mux =
      hit_prof                           ? prof_word  :
      hit_frm || hit_trg                 ? stamp_word :
      BUS_REQ.addr == spc_pkg::ADDR_FRM_VALUE ? frm_cnt :
      BUS_REQ.addr == spc_pkg::ADDR_TRG_VALUE ? trg_cnt :
                                           32'h0000_0000;

  // profile writes that start an operation answer only from the apply state, so the host sees
  // no response until the store, load or boot choice is finished
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      RESP_VALID <= 1'b0;
      RD_DATA    <= 32'h0000_0000;
    end
    else if (CE)
    begin
      RESP_VALID <= (take && !start_op) || (in_apply && !is_start);
      if (take && !BUS_REQ.write)
        RD_DATA <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // side outputs; memory-channel registers are never touched
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      CAPTURE_STOP  <= 1'b0;
      SETTINGS_LOAD <= 1'b0;
      SETTINGS_OUT  <= spc_pkg::FACTORY_PROFILE;
    end
    else if (CE)
    begin
      CAPTURE_STOP  <= start_op && req_store;
      SETTINGS_LOAD <= load_do;
      if (load_do)
        SETTINGS_OUT <= load_data;
    end
  end

  // ----------------------------------------------------------------
  // stamp insertion
  // ----------------------------------------------------------------
  // a negative row counts back from the image height
  wire [15:0] row_abs = stamp_row_reg[15] ? 16'(IMG_HEIGHT + stamp_row_reg)
                                          : stamp_row_reg;
  wire in_win = BYTE_IDX >= spc_pkg::FRM_BYTE_FIRST
             && BYTE_IDX <= spc_pkg::TRG_BYTE_LAST;
  wire stamp_hit = stamp_on_reg && PIX_VALID && LINE_NUM == row_abs
                && in_win;
  wire [31:0] word_sel = (BYTE_IDX < spc_pkg::TRG_BYTE_FIRST)
                       ? frm_cnt : trg_cnt;
  wire [31:0] word_sh  = word_sel >> {~BYTE_IDX[1:0], 3'b000};

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      STAMP_VALID <= 1'b0;
      STAMP_DATA  <= 8'h00;
    end
    else if (CE)
    begin
      STAMP_VALID <= stamp_hit;
      STAMP_DATA  <= stamp_hit ? word_sh[7:0] : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK iff CE);
  endclocking
  default disable iff (!RST_N);

  sequence s_op_start;
    start_op;
  endsequence

  sequence s_op_done;
    !idle ##1 !idle ##1 RESP_VALID && idle;
  endsequence

  AST_FRM_CLEAR: assert property (frm_clr |=> frm_cnt <= 32'h1)
    else $error("frame count not cleared");
  AST_TRG_CLEAR: assert property (trg_clr |=> trg_cnt <= 32'h1)
    else $error("trigger count not cleared");
  AST_MIRROR: assert property (wr_stamp && !load_do |=>
      stamp_on_reg == $past(BUS_REQ.data[spc_pkg::BIT_STAMP]))
    else $error("stamp enable not shared");
  AST_FRM_BYTE: assert property (stamp_hit
      && BYTE_IDX == spc_pkg::FRM_BYTE_FIRST |=>
      STAMP_VALID && STAMP_DATA == $past(frm_cnt[31:24]))
    else $error("frame byte misplaced");
  AST_TRG_BYTE: assert property (stamp_hit
      && BYTE_IDX == spc_pkg::TRG_BYTE_LAST |=>
      STAMP_DATA == $past(trg_cnt[7:0]))
    else $error("trigger byte misplaced");
  AST_PRESENCE: assert property (take && !BUS_REQ.write
      && (hit_prof || hit_frm || hit_trg) |=> RD_DATA[31])
    else $error("presence bit missing");
  AST_ONE_OP: assert property (s_op_start |=> s_op_done)
    else $error("profile answer not after completion");
  AST_SLOT0: assert property (start_op && req_store
      && BUS_REQ.data[3:0] == 4'h0 |-> ##2 !mem_wr
      ##1 fault_reg == spc_pkg::FAULT_RANGE)
    else $error("factory slot written");
  AST_ERR_CLR: assert property (wr_prof && !start_op |=>
      fault_reg == spc_pkg::FAULT_NONE)
    else $error("fault not cleared by write");
  AST_STOP: assert property (start_op && req_store |=> CAPTURE_STOP)
    else $error("capture not stopped");
  AST_FALLBACK: assert property (load_do && !load_ok |=>
      SETTINGS_LOAD && SETTINGS_OUT == spc_pkg::FACTORY_PROFILE)
    else $error("no factory fallback");

endmodule : spc_top

`default_nettype wire

//--- bench/spc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module spc_top_bench;
  // ------------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------------
  localparam logic [31:0] PROF = spc_pkg::ADDR_PROFILE;
  logic               core_clk = 1'b0;
  logic               rst_n = 1'b0;
  spc_pkg::spc_req_t  bus_req = '0;
  logic               resp_valid, capture_stop, settings_load;
  logic               stamp_valid;
  logic [31:0]        rd_data;
  logic [7:0]         stamp_data;
  spc_pkg::spc_prof_t settings_out;
  logic               frame_done = 1'b0, trig_seen = 1'b0;
  logic               init_cmd = 1'b0, capture_busy = 1'b0;
  logic               pix_valid = 1'b0;
  logic [31:0]        settings_in = '0;
  logic [3:0]         table_sel_in = '0;
  logic [15:0]        line_num = '0, byte_idx = '0, img_height = 16'h000a;
  logic [31:0]        rdata;
  logic               stop_seen, load_seen;
  int                 lat, miscompares = 0, checks_done = 0, cycles = 0;

  spc_top u_spc_top (
    .CORE_CLK(core_clk), .RST_N(rst_n), .CE(1'b1), .BUS_REQ(bus_req),
    .RESP_VALID(resp_valid), .RD_DATA(rd_data), .FRAME_DONE(frame_done),
    .TRIG_SEEN(trig_seen), .INIT_CMD(init_cmd),
    .CAPTURE_BUSY(capture_busy), .SETTINGS_IN(settings_in),
    .TABLE_SEL_IN(table_sel_in), .CAPTURE_STOP(capture_stop),
    .SETTINGS_LOAD(settings_load), .SETTINGS_OUT(settings_out),
    .PIX_VALID(pix_valid), .LINE_NUM(line_num), .BYTE_IDX(byte_idx),
    .IMG_HEIGHT(img_height), .STAMP_VALID(stamp_valid),
    .STAMP_DATA(stamp_data)
  );

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask : check

  // request is released after the taking edge so it is not taken twice
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    stop_seen = 1'b0;
    load_seen = 1'b0;
    bus_req = '{valid: 1'b1, write: w, addr: a, data: d};
    @(negedge core_clk);
    bus_req.valid = 1'b0;
    lat = 1;
    forever
    begin
      stop_seen = stop_seen | capture_stop;
      load_seen = load_seen | settings_load;
      if (resp_valid === 1'b1 || lat >= 20)
        break;
      @(negedge core_clk);
      lat++;
    end
    rdata = rd_data;
  endtask : bus

  task automatic pulse(input int nf, input int nt);
    for (int i = 0; i < 8; i++)
    begin
      frame_done = (i < nf);
      trig_seen = (i < nt);
      @(negedge core_clk);
    end
  endtask : pulse

  task automatic stamp_line(input logic [15:0] ln, input logic [31:0] f,
                            input logic [31:0] t);
    for (int i = 4; i < 12; i++)
    begin
      line_num = ln;
      byte_idx = 16'(i);
      pix_valid = 1'b1;
      @(negedge core_clk);
      pix_valid = 1'b0;
      check(stamp_valid, 1'b1, "stamp valid");
      if (i < 8)
        check(stamp_data, f[8*(7-i)+:8], "frame byte");
      else
        check(stamp_data, t[8*(11-i)+:8], "trigger byte");
    end
  endtask : stamp_line

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    bus(1'b1, spc_pkg::ADDR_FRM_CTRL, 32'h0000_0000);
    bus(1'b0, spc_pkg::ADDR_FRM_CTRL, '0);
    check(rdata, 32'h8000_0000, "frame control");
    bus(1'b0, 32'hf100_0700, '0);
    check(rdata, 32'h0000_0000, "unmapped read");
    bus(1'b0, PROF, '0);
    check(rdata[31], 1'b1, "profile present");
    $display("test regs done");
  endtask : t_regs

  task automatic t_count();
    pulse(3, 2);
    bus(1'b0, spc_pkg::ADDR_FRM_VALUE, '0);
    check(rdata, 32'h0000_0003, "frame count");
    bus(1'b0, spc_pkg::ADDR_TRG_VALUE, '0);
    check(rdata, 32'h0000_0002, "trigger count");
    bus(1'b1, spc_pkg::ADDR_FRM_CTRL, 32'h4000_0000);
    bus(1'b0, spc_pkg::ADDR_FRM_VALUE, '0);
    check(rdata, 32'h0000_0000, "frame cleared");
    bus(1'b0, spc_pkg::ADDR_FRM_CTRL, '0);
    check(rdata[30], 1'b0, "frame clear bit");
    bus(1'b0, spc_pkg::ADDR_TRG_VALUE, '0);
    check(rdata, 32'h0000_0002, "trigger kept");
    bus(1'b1, spc_pkg::ADDR_TRG_CTRL, 32'h4000_0000);
    bus(1'b0, spc_pkg::ADDR_TRG_CTRL, '0);
    check(rdata[30], 1'b0, "trigger clear bit");
    bus(1'b0, spc_pkg::ADDR_TRG_VALUE, '0);
    check(rdata, 32'h0000_0000, "trigger cleared");
    $display("test counters done");
  endtask : t_count

  task automatic t_stamp();
    pulse(5, 3);
    bus(1'b1, spc_pkg::ADDR_FRM_CTRL, 32'h0200_0005);
    bus(1'b0, spc_pkg::ADDR_TRG_CTRL, '0);
    check(rdata, 32'h8200_0005, "shared stamp fields");
    stamp_line(16'h0005, 32'h5, 32'h3);
    line_num = 16'h0004;
    pix_valid = 1'b1;
    @(negedge core_clk);
    pix_valid = 1'b0;
    check(stamp_valid, 1'b0, "other line");
    bus(1'b1, spc_pkg::ADDR_TRG_CTRL, 32'h0200_ffff);
    stamp_line(16'h0009, 32'h5, 32'h3);
    $display("test stamp done");
  endtask : t_stamp

  task automatic t_prof();
    bus(1'b1, PROF, 32'h0080_0000);
    check(lat, 3, "store latency");
    bus(1'b0, PROF, '0);
    check(rdata[11:8], 4'h5, "store slot zero");
    bus(1'b1, PROF, 32'h0000_0000);
    bus(1'b0, PROF, '0);
    check(rdata[11:8], 4'h0, "fault cleared");
    settings_in = 32'h1234_5678;
    table_sel_in = 4'h9;
    bus(1'b1, PROF, 32'h0080_0001);
    check(stop_seen, 1'b1, "capture stop");
    check(lat, 3, "store latency");
    settings_in = 32'h0;
    bus(1'b1, PROF, 32'h0040_0001);
    check(load_seen, 1'b1, "load pulse");
    check(settings_out.settings, 32'h1234_5678, "loaded");
    check(settings_out.table_select, 4'h9, "table select");
    bus(1'b0, PROF, '0);
    check(rdata, 32'h8000_0001, "load slot one");
    bus(1'b1, PROF, 32'h0040_0002);
    bus(1'b0, PROF, '0);
    check(rdata, 32'h8000_0400, "missing slot");
    check(settings_out.settings, 32'h0, "factory fallback");
    capture_busy = 1'b1;
    bus(1'b1, PROF, 32'h0040_0001);
    capture_busy = 1'b0;
    bus(1'b0, PROF, '0);
    check(rdata[11:8], 4'h2, "not idle");
    bus(1'b1, PROF, 32'h0020_0001);
    init_cmd = 1'b1;
    @(negedge core_clk);
    init_cmd = 1'b0;
    load_seen = 1'b0;
    repeat (4)
    begin
      @(negedge core_clk);
      load_seen = load_seen | settings_load;
    end
    check(load_seen, 1'b1, "init load");
    check(settings_out.settings, 32'h1234_5678, "default");
    bus(1'b0, PROF, '0);
    check(rdata[3:0], 4'h1, "slot after init");
    $display("test profiles done");
  endtask : t_prof

  // ------------------------------------------------------------------
  // run control
  // ------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      $display("unexpected at %0t: run timed out", $time);
      give_verdict();
    end
  end

  initial
  begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_regs();
    t_count();
    t_stamp();
    t_prof();
    give_verdict();
  end
endmodule : spc_top_bench

`default_nettype wire
